/* File: rtl/tsr_pkg.sv */
package tsr_pkg;
   // Register indices on the local port
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_STAT = 2'h1;
   localparam logic [1:0] ADDR_OWN = 2'h2;
   localparam logic [1:0] ADDR_DATA = 2'h3;
   // Control register fields
   localparam int CTL_FLAG = 7;
   localparam int CTL_ACK = 6;
   localparam int CTL_STA = 5;
   localparam int CTL_STO = 4;
   localparam int CTL_WCOL = 3;
   localparam int CTL_EN = 2;
   localparam int CTL_IE = 0;
   // Own address register field
   localparam int OWN_GCE = 0;
   // Reset values
   localparam logic [7:0] OWN_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'hFF;
   localparam logic [1:0] PRESC_RST = 2'h0;
   // General call address
   localparam logic [6:0] GC_ADDR = 7'h00;
   // Status codes, prescaler bits at zero
   localparam logic [7:0] ST_OWN_W = 8'h60;
   localparam logic [7:0] ST_ARB_OWN = 8'h68;
   localparam logic [7:0] ST_GC = 8'h70;
   localparam logic [7:0] ST_ARB_GC = 8'h78;
   localparam logic [7:0] ST_DAT_ACK = 8'h80;
   localparam logic [7:0] ST_DAT_NACK = 8'h88;
   localparam logic [7:0] ST_GDAT_ACK = 8'h90;
   localparam logic [7:0] ST_GDAT_NACK = 8'h98;
   localparam logic [7:0] ST_STOP = 8'hA0;
   localparam logic [7:0] ST_TX_SEL = 8'hA8;
   localparam logic [7:0] ST_IDLE = 8'hF8;
   localparam logic [7:0] PRESC_MASK = 8'h03;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // Receiver states
   typedef enum logic [2:0] {
      ST_W_IDLE = 3'b000,
      ST_W_ADDR = 3'b001,
      ST_W_DATA = 3'b010,
      ST_W_ACK = 3'b011,
      ST_W_HOLD = 3'b100,
      ST_W_SKIP = 3'b101
   } tsr_fsm_type;
endpackage

/* File: rtl/tsr_slave_rx.sv */
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module tsr_slave_rx (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Two-wire bus pins
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // System side
   input wire logic sleep_deep,
   input wire logic lost_arb,
   output logic wake,
   output logic start_go,
   output logic tx_select
);

   typedef struct packed {
      logic [2:0] scl_sy;
      logic [2:0] sda_sy;
      logic scl_f;
      logic sda_f;
      tsr_pkg::tsr_fsm_type st;
      logic [2:0] cnt;
      logic [7:0] shift;
      logic is_addr;
      logic gc;
      logic ackb;
      logic fall2;
      logic addressed;
      logic busy;
      logic start_pend;
      logic flag;
      logic ack_en;
      logic sta;
      logic sto;
      logic wcol;
      logic en;
      logic ie;
      logic [7:0] own;
      logic [7:0] dreg;
      logic [7:0] stat;
      logic [1:0] presc;
      logic [7:0] rdata;
      logic scl_oe;
      logic sda_oe;
      logic scl_o;
      logic sda_o;
      logic wake;
      logic start_go;
      logic tx_sel;
   } tsr_state_type;

   tsr_state_type s_q;
   tsr_state_type s_d;
   logic scl_new;
   logic sda_new;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic own_hit;
   logic gc_hit;

   // Filtered pin levels: second and third stages must agree
   assign scl_new = (s_q.scl_sy[1] == s_q.scl_sy[2]) ? s_q.scl_sy[2] : s_q.scl_f;
   assign sda_new = (s_q.sda_sy[1] == s_q.sda_sy[2]) ? s_q.sda_sy[2] : s_q.sda_f;
   assign scl_rise = scl_new & ~s_q.scl_f;
   assign scl_fall = ~scl_new & s_q.scl_f;
   assign bus_start = scl_new & s_q.scl_f & s_q.sda_f & ~sda_new;
   assign bus_stop = scl_new & s_q.scl_f & ~s_q.sda_f & sda_new;
   assign own_hit = s_q.shift[6:0] == s_q.own[7:1];
   assign gc_hit = (s_q.shift[6:0] == tsr_pkg::GC_ADDR) && s_q.own[tsr_pkg::OWN_GCE];

   always_comb begin
      logic flag_set;
      logic flag_clr;
      flag_set = 1'b0;
      flag_clr = 1'b0;
      s_d = s_q;
      s_d.scl_sy = {s_q.scl_sy[1:0], scl_in};
      s_d.sda_sy = {s_q.sda_sy[1:0], sda_in};
      s_d.scl_f = scl_new;
      s_d.sda_f = sda_new;
      s_d.rdata = 8'h00;
      s_d.start_go = 1'b0;
      s_d.tx_sel = 1'b0;
      if (bus_start) begin
         s_d.busy = 1'b1;
      end
      if (bus_stop) begin
         s_d.busy = 1'b0;
      end
      if (!sleep_deep) begin
         s_d.wake = 1'b0;
      end
      // Bit engine
      if (!s_q.en || s_q.sto) begin
         s_d.st = tsr_pkg::ST_W_IDLE;
         s_d.addressed = 1'b0;
         s_d.sda_oe = 1'b0;
         s_d.fall2 = 1'b0;
         s_d.sto = 1'b0;
      end else if (bus_start || bus_stop) begin
         if (s_q.addressed) begin
            s_d.stat = tsr_pkg::ST_STOP;
            flag_set = 1'b1;
            s_d.addressed = 1'b0;
            s_d.start_pend = s_q.sta;
         end
         s_d.st = bus_start ? tsr_pkg::ST_W_ADDR : tsr_pkg::ST_W_IDLE;
         s_d.cnt = 3'h0;
         s_d.sda_oe = 1'b0;
         s_d.fall2 = 1'b0;
      end else begin
         unique case (s_q.st)
            tsr_pkg::ST_W_IDLE, tsr_pkg::ST_W_SKIP: begin
               s_d.sda_oe = 1'b0;
            end
            tsr_pkg::ST_W_ADDR, tsr_pkg::ST_W_DATA: begin
               if (scl_rise) begin
                  s_d.shift = {s_q.shift[6:0], sda_new};
                  s_d.cnt = s_q.cnt + 3'h1;
                  if (s_q.cnt == tsr_pkg::LAST_BIT) begin
                     if (s_q.st == tsr_pkg::ST_W_DATA) begin
                        s_d.ackb = s_q.ack_en;
                        s_d.is_addr = 1'b0;
                        s_d.st = tsr_pkg::ST_W_ACK;
                     end else if (s_q.ack_en && (own_hit || gc_hit)) begin
                        s_d.ackb = 1'b1;
                        s_d.is_addr = 1'b1;
                        s_d.gc = gc_hit && !own_hit;
                        s_d.st = tsr_pkg::ST_W_ACK;
                        s_d.wake = sleep_deep;
                     end else begin
                        s_d.st = tsr_pkg::ST_W_SKIP;
                     end
                  end
               end
            end
            tsr_pkg::ST_W_ACK: begin
               if (scl_fall && !s_q.fall2) begin
                  s_d.fall2 = 1'b1;
                  s_d.sda_oe = s_q.ackb;
               end else if (scl_fall) begin
                  s_d.fall2 = 1'b0;
                  s_d.sda_oe = 1'b0;
                  flag_set = 1'b1;
                  if (s_q.is_addr && s_q.shift[0]) begin
                     s_d.stat = tsr_pkg::ST_TX_SEL;
                     s_d.tx_sel = 1'b1;
                     s_d.st = tsr_pkg::ST_W_SKIP;
                  end else if (s_q.is_addr) begin
                     if (s_q.gc) begin
                        s_d.stat = lost_arb ? tsr_pkg::ST_ARB_GC : tsr_pkg::ST_GC;
                     end else begin
                        s_d.stat = lost_arb ? tsr_pkg::ST_ARB_OWN : tsr_pkg::ST_OWN_W;
                     end
                     s_d.addressed = 1'b1;
                     s_d.st = tsr_pkg::ST_W_HOLD;
                  end else begin
                     if (s_q.gc) begin
                        s_d.stat = s_q.ackb ? tsr_pkg::ST_GDAT_ACK : tsr_pkg::ST_GDAT_NACK;
                     end else begin
                        s_d.stat = s_q.ackb ? tsr_pkg::ST_DAT_ACK : tsr_pkg::ST_DAT_NACK;
                     end
                     if (!sleep_deep) begin
                        s_d.dreg = s_q.shift;
                     end
                     s_d.st = tsr_pkg::ST_W_HOLD;
                  end
               end
            end
            tsr_pkg::ST_W_HOLD: begin
               if (!s_q.flag) begin
                  s_d.cnt = 3'h0;
                  if (s_q.ackb) begin
                     s_d.st = tsr_pkg::ST_W_DATA;
                  end else begin
                     s_d.st = tsr_pkg::ST_W_SKIP;
                     s_d.addressed = 1'b0;
                     s_d.start_pend = s_q.sta;
                  end
               end
            end
            default: begin
               s_d.st = tsr_pkg::ST_W_IDLE;
            end
         endcase
      end
      // Deferred START once the bus is free
      if (s_q.start_pend && !s_q.busy && !bus_start) begin
         s_d.start_go = 1'b1;
         s_d.start_pend = 1'b0;
      end
      // Register writes
      if (reg_wr) begin
         unique case (reg_addr)
            tsr_pkg::ADDR_CTRL: begin
               flag_clr = reg_wdata[tsr_pkg::CTL_FLAG];
               s_d.ack_en = reg_wdata[tsr_pkg::CTL_ACK];
               s_d.sta = reg_wdata[tsr_pkg::CTL_STA];
               s_d.sto = reg_wdata[tsr_pkg::CTL_STO];
               s_d.en = reg_wdata[tsr_pkg::CTL_EN];
               s_d.ie = reg_wdata[tsr_pkg::CTL_IE];
            end
            tsr_pkg::ADDR_STAT: begin
               s_d.presc = reg_wdata[1:0];
            end
            tsr_pkg::ADDR_OWN: begin
               s_d.own = reg_wdata;
            end
            tsr_pkg::ADDR_DATA: begin
               if (s_q.flag) begin
                  s_d.dreg = reg_wdata;
                  s_d.wcol = 1'b0;
               end else begin
                  s_d.wcol = 1'b1;
               end
            end
         endcase
      end
      // Register reads, data in the next cycle
      if (reg_rd) begin
         unique case (reg_addr)
            tsr_pkg::ADDR_CTRL: begin
               s_d.rdata = {s_q.flag, s_q.ack_en, s_q.sta, s_q.sto,
                            s_q.wcol, s_q.en, 1'b0, s_q.ie};
            end
            tsr_pkg::ADDR_STAT: begin
               s_d.rdata = (s_q.stat & ~tsr_pkg::PRESC_MASK) | {6'h00, s_q.presc};
            end
            tsr_pkg::ADDR_OWN: begin
               s_d.rdata = s_q.own;
            end
            tsr_pkg::ADDR_DATA: begin
               s_d.rdata = s_q.dreg;
            end
         endcase
      end
      // Hardware set wins over software clear
      s_d.flag = flag_set | (s_q.flag & ~flag_clr);
      if (!s_d.flag && s_q.flag && s_q.stat != tsr_pkg::ST_IDLE && s_d.st != tsr_pkg::ST_W_HOLD) begin
         s_d.stat = tsr_pkg::ST_IDLE;
      end
      s_d.scl_oe = (s_d.st == tsr_pkg::ST_W_HOLD) && s_d.flag;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_q <= '0;
         s_q.scl_sy <= 3'h7;
         s_q.sda_sy <= 3'h7;
         s_q.scl_f <= 1'b1;
         s_q.sda_f <= 1'b1;
         s_q.st <= tsr_pkg::ST_W_IDLE;
         s_q.own <= tsr_pkg::OWN_RST;
         s_q.dreg <= tsr_pkg::DATA_RST;
         s_q.stat <= tsr_pkg::ST_IDLE;
         s_q.presc <= tsr_pkg::PRESC_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign scl_out = s_q.scl_o;
   assign scl_oe = s_q.scl_oe;
   assign sda_out = s_q.sda_o;
   assign sda_oe = s_q.sda_oe;
   assign wake = s_q.wake;
   assign start_go = s_q.start_go;
   assign tx_select = s_q.tx_sel;

   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (srst);

   own_match_a: assert property (
      s_q.st == tsr_pkg::ST_W_ACK && s_q.is_addr && !s_q.gc |-> s_q.shift[7:1] == s_q.own[7:1])
      else $error("acked address differs from own address");
   gc_enable_a: assert property (
      s_q.st == tsr_pkg::ST_W_ACK && s_q.is_addr && s_q.gc |-> s_q.own[tsr_pkg::OWN_GCE])
      else $error("general call acked while disabled");
   addr_ack_a: assert property (
      s_q.st == tsr_pkg::ST_W_ADDR ##1 s_q.st == tsr_pkg::ST_W_ACK |-> $past(s_q.ack_en))
      else $error("address acked with ack enable low");
   nack_drive_a: assert property (
      s_q.st == tsr_pkg::ST_W_ACK && !s_q.ackb |-> !s_q.sda_oe)
      else $error("SDA driven low for a not-acknowledge");
   status_low_a: assert property (
      $rose(s_q.flag) |-> s_q.stat[2:0] == 3'h0 && s_q.stat != tsr_pkg::ST_IDLE)
      else $error("flag raised without a valid status code");
   stretch_hold_a: assert property (
      s_q.st == tsr_pkg::ST_W_HOLD && s_q.flag |=> s_q.scl_oe || !s_q.flag)
      else $error("SCL released while flag still set");
   stop_status_a: assert property (
      s_q.en && !s_q.sto && s_q.addressed && bus_stop |=> s_q.flag && s_q.stat == tsr_pkg::ST_STOP)
      else $error("stop while addressed not reported");
   sleep_data_a: assert property (
      sleep_deep && $rose(s_q.flag) && !$past(reg_wr) |-> $stable(s_q.dreg))
      else $error("data register loaded during deep sleep");
   start_free_a: assert property (
      s_q.start_go |-> !$past(s_q.busy) ##1 !s_q.start_go)
      else $error("START issued while bus busy");

endmodule // tsr_slave_rx

/* File: verification/tsr_bus_master.sv */
`timescale 1ns/10ps
module tsr_bus_master (
   // Clock
   input wire logic clk_sys,
   // Wire levels
   input wire logic scl,
   input wire logic sda,
   // Pull-low enables
   output logic scl_low,
   output logic sda_low
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // Quarter of the 160 ns bus period
   task automatic quarter();
      repeat (4) @(posedge clk_sys);
   endtask
   // Release SCL and wait out any stretch
   task automatic scl_up();
      scl_low <= 1'b0;
      @(posedge clk_sys);
      while (scl !== 1'b1) @(posedge clk_sys);
   endtask
   task automatic start_cond();
      sda_low <= 1'b0;
      quarter();
      scl_up();
      quarter();
      sda_low <= 1'b1;
      quarter();
      scl_low <= 1'b1;
      quarter();
   endtask
   task automatic stop_cond();
      sda_low <= 1'b1;
      quarter();
      scl_up();
      quarter();
      sda_low <= 1'b0;
      quarter();
   endtask
   // Eight bits MSB first, then the acknowledge clock
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         quarter();
         sda_low <= ~b[i];
         quarter();
         scl_up();
         repeat (3) @(posedge clk_sys);
         quarter();
         scl_low <= 1'b1;
      end
      quarter();
      sda_low <= 1'b0;
      quarter();
      scl_up();
      repeat (3) @(posedge clk_sys);
      ack = sda;
      quarter();
      scl_low <= 1'b1;
      quarter();
   endtask
endmodule // tsr_bus_master

/* File: verification/tsr_slave_rx_test.sv */
`timescale 1ns/10ps
module tsr_slave_rx_test;
   logic clk_sys = 0, srst = 1, reg_wr = 0, reg_rd = 0, sleep_deep = 0, lost_arb = 0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rd;
   logic scl_oe, sda_oe, m_scl, m_sda, ack, wake;
   logic scl_o, sda_o, start_go, tx_select;
   int tx_seen = 0, go_seen = 0;
   wire scl = ~(scl_oe | m_scl);
   wire sda = ~(sda_oe | m_sda);
   int errors = 0, checked = 0, cycles = 0;
   always #5 clk_sys = ~clk_sys;
   tsr_slave_rx tsr_slave_rx_i (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .scl_in(scl), .scl_out(scl_o), .scl_oe(scl_oe),
      .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe),
      .sleep_deep(sleep_deep), .lost_arb(lost_arb), .wake(wake), .start_go(start_go),
      .tx_select(tx_select));
   tsr_bus_master tsr_bus_master_i (.clk_sys(clk_sys), .scl(scl), .sda(sda),
      .scl_low(m_scl), .sda_low(m_sda));
   // Count one-cycle pulses from the block
   always @(posedge clk_sys) begin
      if (tx_select) tx_seen <= tx_seen + 1;
      if (start_go) go_seen <= go_seen + 1;
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rdr(input logic [1:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   // Flag must be up and the masked status must match
   task automatic flagged(input logic [7:0] code);
      rdr(tsr_pkg::ADDR_CTRL);
      check("flag", {7'h00, rd[7]}, 8'h01);
      rdr(tsr_pkg::ADDR_STAT);
      check("status", rd & ~tsr_pkg::PRESC_MASK, code);
   endtask
   task automatic clr(input logic [7:0] c);
      wr(tsr_pkg::ADDR_CTRL, c);
   endtask
   task automatic xfer(input logic st, input logic [7:0] b, input logic ea);
      if (st) tsr_bus_master_i.start_cond();
      tsr_bus_master_i.send_byte(b, ack);
      check("ack bit", {7'h00, ack}, {7'h00, ea});
   endtask
   task automatic stop();
      tsr_bus_master_i.stop_cond();
   endtask
   task automatic t_reset();
      rdr(tsr_pkg::ADDR_CTRL);
      check("control", rd, 8'h00);
      rdr(tsr_pkg::ADDR_STAT);
      check("status", rd, tsr_pkg::ST_IDLE);
      rdr(tsr_pkg::ADDR_OWN);
      check("own", rd, tsr_pkg::OWN_RST);
      rdr(tsr_pkg::ADDR_DATA);
      check("data", rd, tsr_pkg::DATA_RST);
      wr(tsr_pkg::ADDR_OWN, 8'h55);
      clr(8'h44);
      rdr(tsr_pkg::ADDR_CTRL);
      check("control", rd, 8'h44);
      wr(tsr_pkg::ADDR_STAT, 8'h03);
      rdr(tsr_pkg::ADDR_STAT);
      check("status", rd, tsr_pkg::ST_IDLE | 8'h03);
      rdr(tsr_pkg::ADDR_OWN);
      check("own", rd, 8'h55);
   endtask
   task automatic t_own();
      xfer(1'b1, 8'h54, 1'b0);
      flagged(tsr_pkg::ST_OWN_W);
      check("stretch", {7'h00, scl_oe}, 8'h01);
      check("drive", {6'h00, scl_o, sda_o}, 8'h00);
      clr(8'hC4);
      repeat (2) @(posedge clk_sys);
      check("release", {7'h00, scl_oe}, 8'h00);
      xfer(1'b0, 8'hA5, 1'b0);
      flagged(tsr_pkg::ST_DAT_ACK);
      rdr(tsr_pkg::ADDR_DATA);
      check("data", rd, 8'hA5);
      clr(8'h84);
      xfer(1'b0, 8'h3C, 1'b1);
      flagged(tsr_pkg::ST_DAT_NACK);
      clr(8'hE4);
      stop();
      repeat (4) @(posedge clk_sys);
      check("start go", go_seen[7:0], 8'h01);
      clr(8'hC4);
      xfer(1'b1, 8'h54, 1'b0);
      flagged(tsr_pkg::ST_OWN_W);
      clr(8'hC4);
      stop();
      flagged(tsr_pkg::ST_STOP);
      clr(8'hC4);
   endtask
   task automatic t_gc();
      xfer(1'b1, 8'h00, 1'b0);
      flagged(tsr_pkg::ST_GC);
      clr(8'hC4);
      xfer(1'b0, 8'h12, 1'b0);
      flagged(tsr_pkg::ST_GDAT_ACK);
      rdr(tsr_pkg::ADDR_DATA);
      check("data", rd, 8'h12);
      clr(8'hC4);
      stop();
      clr(8'hC4);
      wr(tsr_pkg::ADDR_OWN, 8'h54);
      xfer(1'b1, 8'h00, 1'b1);
      stop();
      xfer(1'b1, 8'h56, 1'b1);
      stop();
      rdr(tsr_pkg::ADDR_STAT);
      check("status", rd & ~tsr_pkg::PRESC_MASK, tsr_pkg::ST_IDLE);
      wr(tsr_pkg::ADDR_OWN, 8'h55);
   endtask
   task automatic t_noack();
      clr(8'h04);
      xfer(1'b1, 8'h54, 1'b1);
      stop();
      clr(8'h44);
      xfer(1'b1, 8'h54, 1'b0);
      clr(8'hC4);
      stop();
      clr(8'hC4);
   endtask
   task automatic t_arb();
      lost_arb <= 1'b1;
      xfer(1'b1, 8'h54, 1'b0);
      flagged(tsr_pkg::ST_ARB_OWN);
      clr(8'hC4);
      stop();
      clr(8'hC4);
      xfer(1'b1, 8'h00, 1'b0);
      flagged(tsr_pkg::ST_ARB_GC);
      clr(8'hC4);
      stop();
      clr(8'hC4);
      lost_arb <= 1'b0;
      xfer(1'b1, 8'h55, 1'b0);
      flagged(tsr_pkg::ST_TX_SEL);
      check("tx select", tx_seen[7:0], 8'h01);
      clr(8'hC4);
      stop();
      clr(8'hC4);
   endtask
   task automatic t_sleep();
      sleep_deep <= 1'b1;
      xfer(1'b1, 8'h54, 1'b0);
      flagged(tsr_pkg::ST_OWN_W);
      check("wake", {7'h00, wake}, 8'h01);
      check("stretch", {7'h00, scl_oe}, 8'h01);
      clr(8'hC4);
      xfer(1'b0, 8'h77, 1'b0);
      flagged(tsr_pkg::ST_DAT_ACK);
      rdr(tsr_pkg::ADDR_DATA);
      check("data", rd, 8'h12);
      clr(8'hC4);
      sleep_deep <= 1'b0;
      stop();
      check("wake", {7'h00, wake}, 8'h00);
      clr(8'hC4);
   endtask
   task automatic results();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         errors++;
         results();
      end
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      t_reset();
      t_own();
      t_gc();
      t_noack();
      t_arb();
      t_sleep();
      results();
   end
endmodule // tsr_slave_rx_test
